// ### rtl/link_tx_pkg.sv
package link_tx_pkg;
  // lane count and widths
  localparam int LANES = 2;
  localparam int LANE_W = 64;
  localparam int DATA_W = LANE_W * LANES;
  localparam int SIDE_W = 8;
  localparam int FIFO_DEPTH = 16;
  // reset sequence length in ns, and its cycle count at 25 MHz
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_SEQ_NS = 400;
  localparam int RESET_SEQ_CYC = (RESET_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RESET_SEQ_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [SIDE_W-1:0] SIDE_ZERO = 8'h00;
  // frame word: {first, last, sideband, payload}
  localparam int WORD_W = DATA_W + SIDE_W + 2;
  localparam int POS_LAST = DATA_W + SIDE_W;
  localparam int POS_FIRST = DATA_W + SIDE_W + 1;
  typedef enum logic [1:0] {ST_RESET, ST_WAIT_LOCK, ST_UP} init_state_t;
endpackage

// ### rtl/link_tx_fifo.sv
`timescale 1ns/1ps
module link_tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // honest flags from the occupancy count
  assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_r[rd_r];

  // storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= AW'(wr_r + 1'b1);
      end
      if (pop) begin
        rd_r <= AW'(rd_r + 1'b1);
      end
      cnt_r <= (AW+1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end
endmodule

// ### rtl/link_tx_user_port.sv
`timescale 1ns/1ps
// Summary of operation
// - accept full 64 bits per lane payload
// - capture sideband at burst first and last
// - link ready only after init done
// - user reset held until sequence completes in standard mode; advanced mode takes it from outside
// - accept only after link ready, latency zero
module streaming_link_tx_user_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic advanced_mode_i,
  input wire logic ext_user_reset_i,
  input wire logic pll_locked_i,
  input wire logic [link_tx_pkg::LANES-1:0] serial_clk_i,
  input wire logic [link_tx_pkg::DATA_W-1:0] payload_i,
  input wire logic [link_tx_pkg::SIDE_W-1:0] sideband_i,
  input wire logic payload_valid_i,
  input wire logic burst_first_flag_i,
  input wire logic burst_last_flag_i,
  output logic accept_o,
  output logic link_ready_o,
  output logic user_reset_o,
  output logic [link_tx_pkg::DATA_W-1:0] link_data_o,
  output logic [link_tx_pkg::SIDE_W-1:0] link_start_side_o,
  output logic [link_tx_pkg::SIDE_W-1:0] link_end_side_o,
  output logic link_first_o,
  output logic link_last_o,
  output logic link_valid_o,
  input wire logic link_ready_i,
  output logic [link_tx_pkg::LANES-1:0] lane_clk_seen_o
);
  import link_tx_pkg::*;

  init_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic seq_done;
  logic user_rst;
  logic fifo_in_ready;
  logic [WORD_W-1:0] fifo_in;
  logic [WORD_W-1:0] fifo_out;
  logic fifo_out_valid;
  logic take;
  logic pop;
  logic [SIDE_W-1:0] start_side_r;

  // ************************************************
  // reset sequence and link bring-up
  // ************************************************

  // wait out the sequence, then for the combined lock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_RESET;
      cnt_r <= CNT_ZERO;
    end else begin
      unique case (state_r)
        ST_RESET: begin
          if (cnt_r == CNT_LAST) begin
            state_r <= ST_WAIT_LOCK;
          end else begin
            cnt_r <= CNT_W'(cnt_r + 1'b1);
          end
        end
        ST_WAIT_LOCK: begin
          if (pll_locked_i) begin
            state_r <= ST_UP;
          end
        end
        ST_UP: begin
          if (!pll_locked_i) begin // losing lock drops the link
            state_r <= ST_WAIT_LOCK;
          end
        end
      endcase
    end
  end

  assign seq_done = (state_r != ST_RESET);
  // standard mode makes the reset; advanced mode takes it from outside
  assign user_rst = advanced_mode_i ? ext_user_reset_i : !seq_done;
  assign user_reset_o = user_rst || rst_i;

  // ready only in the up state and outside user reset
  assign link_ready_o = (state_r == ST_UP) && !user_rst;

  // ************************************************
  // user side intake
  // ************************************************

  // zero latency: accept cycle is itself a transfer cycle
  assign accept_o = link_ready_o && fifo_in_ready;
  assign take = accept_o && payload_valid_i;
  assign fifo_in = {burst_first_flag_i, burst_last_flag_i, sideband_i, payload_i};

  link_tx_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(user_reset_o),
    .in_data_i(fifo_in),
    .in_valid_i(take),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(link_ready_i)
  );

  // ************************************************
  // link side output
  // ************************************************

  assign pop = fifo_out_valid && link_ready_i;

  // start sideband held for the whole burst, end sideband taken at last
  always_ff @(posedge clk_i) begin
    if (user_reset_o) begin
      start_side_r <= SIDE_ZERO;
    end else if (pop && fifo_out[POS_FIRST]) begin
      start_side_r <= fifo_out[POS_LAST-1:DATA_W];
    end
  end

  // registered data path towards the serializer
  always_ff @(posedge clk_i) begin
    if (user_reset_o) begin
      link_data_o <= '0;
      link_start_side_o <= SIDE_ZERO;
      link_end_side_o <= SIDE_ZERO;
      link_first_o <= 1'b0;
      link_last_o <= 1'b0;
      link_valid_o <= 1'b0;
    end else begin
      link_valid_o <= pop;
      if (pop) begin
        link_data_o <= fifo_out[DATA_W-1:0];
        link_first_o <= fifo_out[POS_FIRST];
        link_last_o <= fifo_out[POS_LAST];
        link_start_side_o <= fifo_out[POS_FIRST] ? fifo_out[POS_LAST-1:DATA_W]
                                                 : start_side_r;
        if (fifo_out[POS_LAST]) begin
          link_end_side_o <= fifo_out[POS_LAST-1:DATA_W];
        end
      end
    end
  end

  // lane clocks only observed as levels here; serializers use them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lane_clk_seen_o <= '0;
    end else begin
      lane_clk_seen_o <= serial_clk_i;
    end
  end

  // ************************************************
  // checks
  // ************************************************

  // bring-up: accept only from the up state and never inside user reset; ready only after the sequence and a lock
  a_accept_needs_up: assert property (
    @(posedge clk_i) disable iff (rst_i)
    accept_o |-> (state_r == ST_UP) && !user_reset_o)
    else $error("accept without link ready");

  a_ready_after_seq: assert property (
    @(posedge clk_i) disable iff (rst_i)
    link_ready_o |-> seq_done && $past(pll_locked_i))
    else $error("link ready before init");

  // lock loss must drop the link at once, not after a sequence
  a_ready_drops_lock: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_r == ST_UP && !pll_locked_i) |=> !link_ready_o)
    else $error("link ready kept after lock loss");

  // standard mode: user reset covers management reset and the whole sequence
  a_std_reset_held: assert property (
    @(posedge clk_i)
    (!advanced_mode_i && (rst_i || state_r == ST_RESET)) |-> user_reset_o)
    else $error("user reset low in reset");

  a_std_reset_release: assert property (
    @(posedge clk_i)
    (!advanced_mode_i && !rst_i && seq_done) |-> !user_reset_o)
    else $error("user reset not released");

  a_adv_reset_follow: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (advanced_mode_i && ext_user_reset_i) |-> user_reset_o && !link_ready_o)
    else $error("external reset ignored");

  // ten cycles of sequence after release, counted from the release edge
  a_seq_length: assert property (
    @(posedge clk_i)
    $fell(rst_i) |-> !seq_done [*8] ##1 !seq_done [*2] ##1 seq_done)
    else $error("reset sequence length wrong");

  // link side: one registered word per pop, nothing without a pop
  a_output_valid_pop: assert property (
    @(posedge clk_i) disable iff (user_reset_o)
    pop |=> link_valid_o)
    else $error("popped word not presented");

  a_valid_only_pop: assert property (
    @(posedge clk_i) disable iff (user_reset_o)
    !pop |=> !link_valid_o)
    else $error("valid without a popped word");

  a_data_follows_pop: assert property (
    @(posedge clk_i) disable iff (user_reset_o)
    pop |=> link_data_o == $past(fifo_out[DATA_W-1:0]))
    else $error("payload not carried whole");

  // sideband: start value for the whole burst, end value at the last word
  a_end_side_taken: assert property (
    @(posedge clk_i) disable iff (user_reset_o)
    (pop && fifo_out[POS_LAST]) |=> link_end_side_o == $past(fifo_out[POS_LAST-1:DATA_W]))
    else $error("end sideband not captured");

  a_end_side_holds: assert property (
    @(posedge clk_i) disable iff (user_reset_o)
    (pop && !fifo_out[POS_LAST]) |=> $stable(link_end_side_o))
    else $error("end sideband changed inside burst");

  a_first_side_taken: assert property (
    @(posedge clk_i) disable iff (user_reset_o)
    (pop && fifo_out[POS_FIRST]) |=> start_side_r == $past(fifo_out[POS_LAST-1:DATA_W]))
    else $error("start sideband not held");

  a_start_side_first: assert property (
    @(posedge clk_i) disable iff (user_reset_o)
    (pop && fifo_out[POS_FIRST]) |=> link_start_side_o == $past(fifo_out[POS_LAST-1:DATA_W]))
    else $error("start sideband not sent with first");

  a_start_side_body: assert property (
    @(posedge clk_i) disable iff (user_reset_o)
    (pop && !fifo_out[POS_FIRST]) |=> link_start_side_o == $past(start_side_r))
    else $error("start sideband lost inside burst");

endmodule

// ### testbench/pll_model.sv
`timescale 1ns/1ps
module pll_model (
  input wire logic [link_tx_pkg::LANES-1:0] lock_i,
  output logic locked_o,
  output logic [link_tx_pkg::LANES-1:0] serial_clk_o
);
  // ****************
  // lock merge
  // ****************
  // one lagging pll must hold the whole link down
  assign locked_o = &lock_i;
  // one fast clock per lane, free running; odd-ns edges never meet a user clock edge
  initial begin
    serial_clk_o = '0;
    #1;
    forever #6 serial_clk_o = ~serial_clk_o;
  end
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import link_tx_pkg::*;
  localparam int RW = DATA_W + SIDE_W + 2;
  logic clk_i;
  logic rst_i = 1'b1, adv = 1'b0, ext_rst = 1'b0, vld = 1'b0, lnk_rdy = 1'b0;
  logic ok, acc, rdy, urst, lv, lf, ll, locked;
  logic [LANES-1:0] lock = '0, sclk, seen, sq;
  logic [RW-1:0] w = '0;
  logic [DATA_W-1:0] ld;
  logic [SIDE_W-1:0] ss, es, ssx;
  logic [RW+SIDE_W-1:0] got[$];
  logic [RW-1:0] rows [4] = '{
    {2'b10, 8'h5A, 64'h0123456789ABCDEF, 64'hFEDCBA9876543210},
    {2'b00, 8'h33, 64'hFFFFFFFFFFFFFFFF, 64'h0000000000000001},
    {2'b01, 8'h00, 64'h8000000000000000, 64'hA5A5A5A5A5A5A5A5},
    {2'b11, 8'h01, 64'h5555AAAA5555AAAA, 64'h0F0F0F0F0F0F0F0F}};
  int num_errors = 0, num_checks = 0, n;
  pll_model pll_model_inst (.lock_i(lock), .locked_o(locked), .serial_clk_o(sclk));
  streaming_link_tx_user_port streaming_link_tx_user_port_inst (.clk_i(clk_i), .rst_i(rst_i),
    .advanced_mode_i(adv), .ext_user_reset_i(ext_rst), .pll_locked_i(locked),
    .serial_clk_i(sclk), .payload_i(w[DATA_W-1:0]), .sideband_i(w[DATA_W+7:DATA_W]),
    .payload_valid_i(vld), .burst_first_flag_i(w[DATA_W+9]), .burst_last_flag_i(w[DATA_W+8]),
    .accept_o(acc), .link_ready_o(rdy), .user_reset_o(urst), .link_data_o(ld),
    .link_start_side_o(ss), .link_end_side_o(es), .link_first_o(lf), .link_last_o(ll),
    .link_valid_o(lv), .link_ready_i(lnk_rdy), .lane_clk_seen_o(seen));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // record every word the link side hands on
  always @(posedge clk_i) if (lv === 1'b1) got.push_back({lf, ll, ss, es, ld});
  // lane clock levels as the design should have seen them
  always @(posedge clk_i) sq <= sclk;
  task automatic chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // run cycles with the current inputs, counting accepted cycles in n
  task automatic cycles(input int k);
    repeat (k) begin
      @(negedge clk_i);
      ok = acc;
      @(posedge clk_i);
      if (ok === 1'b1 && vld === 1'b1) n++;
    end
  endtask
  initial begin
    // ****************
    // reset and bring-up
    // ****************
    repeat (16) @(posedge clk_i);
    chk(urst, 1'b1);
    chk(acc | rdy, 1'b0);
    rst_i <= 1'b0;
    lock <= 2'b01;
    n = 0;
    cycles(20);
    chk(urst, 1'b0);
    chk(rdy, 1'b0);
    lock <= 2'b11;
    n = 0;
    while (rdy !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk_i);
    end
    chk(rdy, 1'b1);
    repeat (3) begin
      cycles(1);
      chk(seen, sq);
    end
    // ****************
    // table of burst words, back to back
    // ****************
    lnk_rdy <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      w <= rows[i];
      vld <= 1'b1;
      n = 0;
      for (int t = 0; t < 20 && n == 0; t++) cycles(1);
      chk(ok & rdy, 1'b1);
    end
    vld <= 1'b0;
    cycles(10);
    chk(got.size(), 4);
    for (int i = 0; i < 4 && i < got.size(); i++) begin
      if (rows[i][DATA_W+9]) ssx = rows[i][DATA_W+7:DATA_W];
      chk(got[i][DATA_W-1:0], rows[i][DATA_W-1:0]);
      chk(got[i][DATA_W+17:DATA_W+16], rows[i][DATA_W+9:DATA_W+8]);
      chk(got[i][DATA_W+15:DATA_W+8], ssx);
      if (rows[i][DATA_W+8]) chk(got[i][DATA_W+7:DATA_W], rows[i][DATA_W+7:DATA_W]);
    end
    // ****************
    // fill while stalled, then drain
    // ****************
    lnk_rdy <= 1'b0;
    vld <= 1'b1;
    n = 0;
    cycles(30);
    chk(n, FIFO_DEPTH);
    vld <= 1'b0;
    got.delete();
    lnk_rdy <= 1'b1;
    cycles(40);
    chk(got.size(), FIFO_DEPTH);
    // ****************
    // advanced mode: outside reset
    // ****************
    adv <= 1'b1;
    ext_rst <= 1'b1;
    cycles(3);
    chk(urst, 1'b1);
    chk(rdy | acc, 1'b0);
    ext_rst <= 1'b0;
    cycles(2);
    chk(rdy, 1'b1);
    // ****************
    // management reset in mid-run, then lock loss
    // ****************
    adv <= 1'b0;
    rst_i <= 1'b1;
    cycles(2);
    chk(urst, 1'b1);
    chk(rdy, 1'b0);
    rst_i <= 1'b0;
    cycles(RESET_SEQ_CYC);
    chk(urst, 1'b1);
    cycles(1);
    chk(urst, 1'b0);
    chk(rdy, 1'b0);
    cycles(1);
    chk(rdy, 1'b1);
    lock <= 2'b10;
    cycles(2);
    chk(rdy, 1'b0);
    lock <= 2'b11;
    cycles(2);
    chk(rdy, 1'b1);
    print_verdict();
  end
endmodule
